// File: pfdc_map.svh
/*
  Register offsets, field positions and reset values of the feedback
  divider and crystal oscillator control block, as `define macros.
  Assumes it is included by its bare name, before the package.
*/
`ifndef PFDC_MAP_SVH
`define PFDC_MAP_SVH

`define PFDC_DW 36
`define PFDC_AW 8
`define PFDC_OFS_REF_CTRL 8'h02
`define PFDC_OFS_REF_BUF 8'h03
`define PFDC_OFS_XTAL_A 8'h04
`define PFDC_OFS_PLL1_DIV 8'h06
`define PFDC_OFS_PLL1_CTRL 8'h07
`define PFDC_OFS_PLL2_DIV 8'h08
`define PFDC_OFS_PLL2_CTRL 8'h09
`define PFDC_OFS_XTAL_B 8'h0A
`define PFDC_OFS_PLL1_DEN 8'h10
`define PFDC_OFS_PLL2_DEN 8'h11

`define PFDC_ORDER_HI 31
`define PFDC_ORDER_LO 29
`define PFDC_PHSEL_HI 27
`define PFDC_PHSEL_LO 26
`define PFDC_DIVRST_BIT 14
`define PFDC_RATIONAL_BIT 2
`define PFDC_WHOLE_HI 35
`define PFDC_WHOLE_LO 28
`define PFDC_FRAC_HI 27

`define PFDC_PICK1_EN_BIT 4
`define PFDC_PICK1_BIT 5
`define PFDC_PICK2_EN_BIT 6
`define PFDC_PICK2_BIT 7
`define PFDC_XTAL_A_FORCE_BIT 26
`define PFDC_XTAL_TRIM_BIT 15
`define PFDC_XTAL_CAP_HI 14
`define PFDC_XTAL_CAP_LO 12
`define PFDC_XTAL_A_GAIN_LO 8
`define PFDC_XTAL_B_GAIN_LO 9
`define PFDC_XTAL_B_FORCE_BIT 8

`define PFDC_CTRL_RST 32'h0000_0000
`define PFDC_DIV_RST 36'h0_0000_0000
`define PFDC_CFG16_RST 16'h0000
`define PFDC_REF_CTRL_RST 24'h00_0000
`define PFDC_NUM_STAGES 4
`define PFDC_RES_W 28

`endif

// File: pfdc_pkg.sv
/*
  Types shared by the feedback divider control block and its modulator.
  Assumes pfdc_map.svh is on the include path.
*/
`include "pfdc_map.svh"
package pfdc_pkg;

  // Operating mode of one feedback divider, one-hot
  typedef enum logic [2:0] {
    PFDC_MODE_INT = 3'b001,
    PFDC_MODE_FRAC = 3'b010,
    PFDC_MODE_RAT = 3'b100
  } pfdc_mode_type;

  // Everything the modulator needs for one loop
  typedef struct packed {
    logic [2:0] order;
    logic [1:0] phase_sel;
    logic rational;
    logic [7:0] whole;
    logic [27:0] frac;
    logic [15:0] denominator;
  } pfdc_pll_cfg_type;

  // Analog settings of one crystal amplifier
  typedef struct packed {
    logic low_freq_trim;
    logic [2:0] load_cap_sel;
    logic [2:0] amp_gain;
  } pfdc_xtal_cfg_type;

endpackage : pfdc_pkg

// File: pfdc_mod_stage.sv
/*
  One modulus accumulator stage of the noise-shaping modulator.
  Assumes the caller keeps x below m and m non-zero while enabled.
*/
`timescale 1ns/100ps
module pfdc_mod_stage (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic en,
  input wire logic [27:0] x,
  input wire logic [28:0] m,
  output logic [27:0] acc_r,
  output logic carry
);

  logic [28:0] sum;
  logic [28:0] wrapped;

  // Overflow past the modulus is the carry fed to the output sum
  always_comb begin
    sum = {1'b0, acc_r} + {1'b0, x};
    wrapped = sum - m;
    carry = en && (sum >= m);
  end

  // Disabled stages hold zero so a later enable starts clean
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= 28'h000_0000;
    end else if (clr || !en) begin
      acc_r <= 28'h000_0000;
    end else if (carry) begin
      acc_r <= wrapped[27:0];
    end else begin
      acc_r <= sum[27:0];
    end
  end

endmodule : pfdc_mod_stage

// File: pfdc_modulator.sv
/*
  Cascaded noise-shaping modulator for one feedback divider.
  Emits a divide value in eighths each reference cycle.
  Assumes cfg is stable between register writes.
*/
`include "pfdc_map.svh"
`timescale 1ns/100ps
module pfdc_modulator
  import pfdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic div_rst,
  input wire pfdc_pll_cfg_type cfg,
  output logic [8:0] whole_r,
  output logic [2:0] phase_r
);

  logic run;
  logic [2:0] upper8;
  logic [27:0] x0;
  logic [28:0] modulus;
  logic [27:0] acc [`PFDC_NUM_STAGES];
  logic [`PFDC_NUM_STAGES-1:0] c;
  logic [`PFDC_NUM_STAGES-1:0] cd1_r;
  logic [`PFDC_NUM_STAGES-1:0] cd2_r;
  logic [`PFDC_NUM_STAGES-1:0] cd3_r;
  logic signed [6:0] y;
  logic signed [13:0] total8;

  // Residue and modulus: 2^(25+S) for fractional, C over D for rational
  always_comb begin
    run = (cfg.order != 3'h0);
    upper8 = (cfg.phase_sel == 2'h3) ? 3'h0
      : (cfg.frac[27:25] & (3'h7 << cfg.phase_sel));
    if (cfg.rational) begin
      x0 = {12'h000, cfg.frac[24:9]};
      modulus = {13'h0000, cfg.denominator};
      run = run && (cfg.denominator != 16'h0000);
    end else begin
      modulus = 29'h0000_0001 << (5'd25 + {3'h0, cfg.phase_sel});
      x0 = cfg.frac & (modulus[27:0] - 28'h000_0001);
    end
  end

  // Stage i runs only when the selected order reaches it
  genvar gi;
  generate
    for (gi = 0; gi < `PFDC_NUM_STAGES; gi++) begin : g_stage
      pfdc_mod_stage u_stage (
        .clk(clk),
        .rst_n(rst_n),
        .clr(div_rst),
        .en(run && (gi < cfg.order)),
        .x((gi == 0) ? x0 : acc[(gi == 0) ? 0 : gi-1]),
        .m(modulus),
        .acc_r(acc[gi]),
        .carry(c[gi])
      );
    end
  endgenerate

  // Carry history for the difference terms
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cd1_r <= 4'h0;
      cd2_r <= 4'h0;
      cd3_r <= 4'h0;
    end else if (div_rst) begin
      cd1_r <= 4'h0;
      cd2_r <= 4'h0;
      cd3_r <= 4'h0;
    end else begin
      cd1_r <= c;
      cd2_r <= cd1_r;
      cd3_r <= cd2_r;
    end
  end

  // Higher stages add zero-mean terms, so the average stays the ratio
  always_comb begin
    y = $signed({6'h00, c[0]})
      + $signed({6'h00, c[1]}) - $signed({6'h00, cd1_r[1]})
      + $signed({6'h00, c[2]}) - $signed({5'h00, cd1_r[2], 1'b0}) + $signed({6'h00, cd2_r[2]})
      + $signed({6'h00, c[3]}) - $signed({5'h00, cd1_r[3], cd1_r[3]})
      - $signed({6'h00, cd1_r[3]}) + $signed({5'h00, cd2_r[3], cd2_r[3]})
      + $signed({6'h00, cd2_r[3]}) - $signed({6'h00, cd3_r[3]});
    total8 = $signed({3'h0, cfg.whole, 3'h0}) + $signed({11'h000, upper8})
      + ($signed({{7{y[6]}}, y}) <<< cfg.phase_sel);
  end

  // Negative excursions near a zero whole part are held at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      whole_r <= 9'h000;
      phase_r <= 3'h0;
    end else if (total8[13]) begin
      whole_r <= 9'h000;
      phase_r <= 3'h0;
    end else begin
      whole_r <= total8[11:3];
      phase_r <= total8[2:0];
    end
  end

endmodule : pfdc_modulator

// File: pfdc_ctrl.sv
/*
  Feedback divider and crystal oscillator control for two PLLs.
  Holds the register file, derives modes, reference picks and
  crystal power, and runs one modulator per PLL.
  Assumes the register port is driven from logic on REF_CLK.
*/
`include "pfdc_map.svh"
`timescale 1ns/100ps
module pfdc_ctrl
  import pfdc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic REG_WR,
  input wire logic [`PFDC_AW-1:0] REG_ADDR,
  input wire logic [`PFDC_DW-1:0] REG_WDATA,
  output logic [`PFDC_DW-1:0] REG_RDATA,
  output logic [8:0] PLL1_FB_WHOLE,
  output logic [2:0] PLL1_FB_PHASE,
  output logic [8:0] PLL2_FB_WHOLE,
  output logic [2:0] PLL2_FB_PHASE,
  output pfdc_mode_type PLL1_MODE,
  output pfdc_mode_type PLL2_MODE,
  output logic PLL1_REF_B,
  output logic PLL2_REF_B,
  output logic PLL1_DIV_RST,
  output logic PLL2_DIV_RST,
  output logic OSC_A_ON,
  output logic OSC_B_ON,
  output pfdc_xtal_cfg_type XTAL_A_CFG,
  output pfdc_xtal_cfg_type XTAL_B_CFG
);

  // Register file
  logic [23:0] ref_ctrl_r;
  logic [31:0] ref_buf_r;
  logic [15:0] crystal_a_and_output_format_cfg_r;
  logic [15:0] crystal_b_and_sync_cfg_r;
  logic [35:0] pll1_div_r;
  logic [35:0] pll2_div_r;
  logic [31:0] pll1_ctrl_r;
  logic [31:0] pll2_ctrl_r;
  logic [15:0] pll1_den_r;
  logic [15:0] pll2_den_r;

  // Divider reset strobes and decoded write enables
  logic pll1_rst_nxt;
  logic pll2_rst_nxt;
  logic pll1_rst_r;
  logic pll2_rst_r;
  logic wr_ref_ctrl;
  logic wr_ref_buf;
  logic wr_xtal_a;
  logic wr_xtal_b;
  logic wr_pll1_div;
  logic wr_pll2_div;
  logic wr_pll1_ctrl;
  logic wr_pll2_ctrl;
  logic wr_pll1_den;
  logic wr_pll2_den;

  // Derived configuration
  pfdc_pll_cfg_type pll1_cfg;
  pfdc_pll_cfg_type pll2_cfg;
  pfdc_mode_type pll1_mode_nxt;
  pfdc_mode_type pll2_mode_nxt;
  logic pll1_ref_b_nxt;
  logic pll2_ref_b_nxt;
  logic osc_a_on_nxt;
  logic osc_b_on_nxt;
  logic reference_buffer_out_b;
  logic [`PFDC_DW-1:0] rdata_nxt;
  logic [8:0] m1_whole;
  logic [2:0] m1_phase;
  logic [8:0] m2_whole;
  logic [2:0] m2_phase;

  // Address decode; unmapped writes are dropped
  always_comb begin
    wr_ref_ctrl = REG_WR && (REG_ADDR == `PFDC_OFS_REF_CTRL);
    wr_ref_buf = REG_WR && (REG_ADDR == `PFDC_OFS_REF_BUF);
    wr_xtal_a = REG_WR && (REG_ADDR == `PFDC_OFS_XTAL_A);
    wr_xtal_b = REG_WR && (REG_ADDR == `PFDC_OFS_XTAL_B);
    wr_pll1_div = REG_WR && (REG_ADDR == `PFDC_OFS_PLL1_DIV);
    wr_pll2_div = REG_WR && (REG_ADDR == `PFDC_OFS_PLL2_DIV);
    wr_pll1_ctrl = REG_WR && (REG_ADDR == `PFDC_OFS_PLL1_CTRL);
    wr_pll2_ctrl = REG_WR && (REG_ADDR == `PFDC_OFS_PLL2_CTRL);
    wr_pll1_den = REG_WR && (REG_ADDR == `PFDC_OFS_PLL1_DEN);
    wr_pll2_den = REG_WR && (REG_ADDR == `PFDC_OFS_PLL2_DEN);
  end

  // Reference control and buffer registers
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ref_ctrl_r <= `PFDC_REF_CTRL_RST;
      ref_buf_r <= `PFDC_CTRL_RST;
    end else begin
      if (wr_ref_ctrl) begin
        ref_ctrl_r <= REG_WDATA[23:0];
      end
      if (wr_ref_buf) begin
        ref_buf_r <= REG_WDATA[31:0];
      end
    end
  end

  // Crystal configuration registers; output mode and sync bits only stored
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      crystal_a_and_output_format_cfg_r <= `PFDC_CFG16_RST;
      crystal_b_and_sync_cfg_r <= `PFDC_CFG16_RST;
    end else begin
      if (wr_xtal_a) begin
        crystal_a_and_output_format_cfg_r <= REG_WDATA[15:0];
      end
      if (wr_xtal_b) begin
        crystal_b_and_sync_cfg_r <= REG_WDATA[15:0];
      end
    end
  end

  // Divider value registers, whole part above the fraction
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pll1_div_r <= `PFDC_DIV_RST;
      pll2_div_r <= `PFDC_DIV_RST;
    end else begin
      if (wr_pll1_div) begin
        pll1_div_r <= REG_WDATA;
      end
      if (wr_pll2_div) begin
        pll2_div_r <= REG_WDATA;
      end
    end
  end

  // Loop control registers; the divider reset bit never stores
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pll1_ctrl_r <= `PFDC_CTRL_RST;
      pll2_ctrl_r <= `PFDC_CTRL_RST;
    end else begin
      if (wr_pll1_ctrl) begin
        pll1_ctrl_r <= REG_WDATA[31:0] & ~(32'h0000_0001 << `PFDC_DIVRST_BIT);
      end
      if (wr_pll2_ctrl) begin
        pll2_ctrl_r <= REG_WDATA[31:0] & ~(32'h0000_0001 << `PFDC_DIVRST_BIT);
      end
    end
  end

  // Rational modulus registers
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pll1_den_r <= `PFDC_CFG16_RST;
      pll2_den_r <= `PFDC_CFG16_RST;
    end else begin
      if (wr_pll1_den) begin
        pll1_den_r <= REG_WDATA[15:0];
      end
      if (wr_pll2_den) begin
        pll2_den_r <= REG_WDATA[15:0];
      end
    end
  end

  // A one written to bit 14 gives a single-cycle divider reset
  always_comb begin
    pll1_rst_nxt = wr_pll1_ctrl && REG_WDATA[`PFDC_DIVRST_BIT];
    pll2_rst_nxt = wr_pll2_ctrl && REG_WDATA[`PFDC_DIVRST_BIT];
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pll1_rst_r <= 1'b0;
      pll2_rst_r <= 1'b0;
    end else begin
      pll1_rst_r <= pll1_rst_nxt;
      pll2_rst_r <= pll2_rst_nxt;
    end
  end

  // Pack the modulator settings of each loop
  always_comb begin
    pll1_cfg.order = pll1_ctrl_r[`PFDC_ORDER_HI:`PFDC_ORDER_LO];
    pll1_cfg.phase_sel = pll1_ctrl_r[`PFDC_PHSEL_HI:`PFDC_PHSEL_LO];
    pll1_cfg.rational = pll1_ctrl_r[`PFDC_RATIONAL_BIT];
    pll1_cfg.whole = pll1_div_r[`PFDC_WHOLE_HI:`PFDC_WHOLE_LO];
    pll1_cfg.frac = pll1_div_r[`PFDC_FRAC_HI:0];
    pll1_cfg.denominator = pll1_den_r;
    pll2_cfg.order = pll2_ctrl_r[`PFDC_ORDER_HI:`PFDC_ORDER_LO];
    pll2_cfg.phase_sel = pll2_ctrl_r[`PFDC_PHSEL_HI:`PFDC_PHSEL_LO];
    pll2_cfg.rational = pll2_ctrl_r[`PFDC_RATIONAL_BIT];
    pll2_cfg.whole = pll2_div_r[`PFDC_WHOLE_HI:`PFDC_WHOLE_LO];
    pll2_cfg.frac = pll2_div_r[`PFDC_FRAC_HI:0];
    pll2_cfg.denominator = pll2_den_r;
  end

  // Order zero is integer whatever the fraction holds; rational needs order
  always_comb begin
    if (pll1_cfg.order == 3'h0) begin
      pll1_mode_nxt = PFDC_MODE_INT;
    end else if (pll1_cfg.rational) begin
      pll1_mode_nxt = PFDC_MODE_RAT;
    end else begin
      pll1_mode_nxt = PFDC_MODE_FRAC;
    end
    if (pll2_cfg.order == 3'h0) begin
      pll2_mode_nxt = PFDC_MODE_INT;
    end else if (pll2_cfg.rational) begin
      pll2_mode_nxt = PFDC_MODE_RAT;
    end else begin
      pll2_mode_nxt = PFDC_MODE_FRAC;
    end
  end

  // Reference picks: second reference only with its enable bit set
  always_comb begin
    pll1_ref_b_nxt = ref_ctrl_r[`PFDC_PICK1_EN_BIT] && ref_ctrl_r[`PFDC_PICK1_BIT];
    pll2_ref_b_nxt = ref_ctrl_r[`PFDC_PICK2_EN_BIT] && ref_ctrl_r[`PFDC_PICK2_BIT];
    reference_buffer_out_b = ref_buf_r[27];
  end

  // Crystal power follows use; force bits pre-warm a crystal, B's only while a pick bit is set
  always_comb begin
    osc_a_on_nxt = !pll1_ref_b_nxt || !pll2_ref_b_nxt || !reference_buffer_out_b
      || ref_buf_r[`PFDC_XTAL_A_FORCE_BIT];
    osc_b_on_nxt = pll1_ref_b_nxt || pll2_ref_b_nxt || reference_buffer_out_b;
    if (crystal_b_and_sync_cfg_r[`PFDC_XTAL_B_FORCE_BIT]
        && (ref_ctrl_r[`PFDC_PICK1_BIT] || ref_ctrl_r[`PFDC_PICK2_BIT])) begin
      osc_b_on_nxt = 1'b1;
    end
  end

  // One modulator per loop, cleared by its divider reset
  pfdc_modulator u_mod1 (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .div_rst(pll1_rst_r),
    .cfg(pll1_cfg),
    .whole_r(m1_whole),
    .phase_r(m1_phase)
  );

  pfdc_modulator u_mod2 (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .div_rst(pll2_rst_r),
    .cfg(pll2_cfg),
    .whole_r(m2_whole),
    .phase_r(m2_phase)
  );

  // Divider outputs retimed so every port leaves a flop
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PLL1_FB_WHOLE <= 9'h000;
      PLL1_FB_PHASE <= 3'h0;
      PLL2_FB_WHOLE <= 9'h000;
      PLL2_FB_PHASE <= 3'h0;
      PLL1_DIV_RST <= 1'b0;
      PLL2_DIV_RST <= 1'b0;
    end else begin
      PLL1_FB_WHOLE <= m1_whole;
      PLL1_FB_PHASE <= m1_phase;
      PLL2_FB_WHOLE <= m2_whole;
      PLL2_FB_PHASE <= m2_phase;
      PLL1_DIV_RST <= pll1_rst_r;
      PLL2_DIV_RST <= pll2_rst_r;
    end
  end

  // Mode and reference outputs
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PLL1_MODE <= PFDC_MODE_INT;
      PLL2_MODE <= PFDC_MODE_INT;
      PLL1_REF_B <= 1'b0;
      PLL2_REF_B <= 1'b0;
    end else begin
      PLL1_MODE <= pll1_mode_nxt;
      PLL2_MODE <= pll2_mode_nxt;
      PLL1_REF_B <= pll1_ref_b_nxt;
      PLL2_REF_B <= pll2_ref_b_nxt;
    end
  end

  // Crystal amplifier controls
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      OSC_A_ON <= 1'b0;
      OSC_B_ON <= 1'b0;
      XTAL_A_CFG <= '0;
      XTAL_B_CFG <= '0;
    end else begin
      OSC_A_ON <= osc_a_on_nxt;
      OSC_B_ON <= osc_b_on_nxt;
      XTAL_A_CFG.low_freq_trim <= crystal_a_and_output_format_cfg_r[`PFDC_XTAL_TRIM_BIT];
      XTAL_A_CFG.load_cap_sel <=
        crystal_a_and_output_format_cfg_r[`PFDC_XTAL_CAP_HI:`PFDC_XTAL_CAP_LO];
      XTAL_A_CFG.amp_gain <=
        crystal_a_and_output_format_cfg_r[`PFDC_XTAL_A_GAIN_LO+:3];
      XTAL_B_CFG.low_freq_trim <= crystal_b_and_sync_cfg_r[`PFDC_XTAL_TRIM_BIT];
      XTAL_B_CFG.load_cap_sel <=
        crystal_b_and_sync_cfg_r[`PFDC_XTAL_CAP_HI:`PFDC_XTAL_CAP_LO];
      XTAL_B_CFG.amp_gain <= crystal_b_and_sync_cfg_r[`PFDC_XTAL_B_GAIN_LO+:3];
    end
  end

  // Read mux; unmapped addresses and absent upper bits read zero
  always_comb begin
    case (REG_ADDR)
      `PFDC_OFS_REF_CTRL: rdata_nxt = {12'h000, ref_ctrl_r};
      `PFDC_OFS_REF_BUF: rdata_nxt = {4'h0, ref_buf_r};
      `PFDC_OFS_XTAL_A: rdata_nxt = {20'h0_0000, crystal_a_and_output_format_cfg_r};
      `PFDC_OFS_PLL1_DIV: rdata_nxt = pll1_div_r;
      `PFDC_OFS_PLL1_CTRL: rdata_nxt = {4'h0, pll1_ctrl_r};
      `PFDC_OFS_PLL2_DIV: rdata_nxt = pll2_div_r;
      `PFDC_OFS_PLL2_CTRL: rdata_nxt = {4'h0, pll2_ctrl_r};
      `PFDC_OFS_XTAL_B: rdata_nxt = {20'h0_0000, crystal_b_and_sync_cfg_r};
      `PFDC_OFS_PLL1_DEN: rdata_nxt = {20'h0_0000, pll1_den_r};
      `PFDC_OFS_PLL2_DEN: rdata_nxt = {20'h0_0000, pll2_den_r};
      default: rdata_nxt = 36'h0_0000_0000;
    endcase
  end

  // Read data is registered, one cycle behind the address
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= 36'h0_0000_0000;
    end else begin
      REG_RDATA <= rdata_nxt;
    end
  end

endmodule : pfdc_ctrl

// File: pfdc_checker.sv
/*
  Port assertions for the feedback divider control block.
  Assumes a bind to pfdc_ctrl, one clock REF_CLK and RSTN active low.
*/
`include "pfdc_map.svh"
`timescale 1ns/100ps
module pfdc_checker
  import pfdc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic REG_WR,
  input wire logic [`PFDC_AW-1:0] REG_ADDR,
  input wire logic [`PFDC_DW-1:0] REG_WDATA,
  input wire pfdc_mode_type PLL1_MODE,
  input wire logic PLL1_REF_B,
  input wire logic PLL1_DIV_RST,
  input wire logic OSC_B_ON,
  input wire pfdc_xtal_cfg_type XTAL_A_CFG,
  input wire pfdc_xtal_cfg_type XTAL_B_CFG
);
  logic [6:0] xa_r;
  logic [6:0] xb_r;
  logic ctl_wr;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  // Loop 1 control write
  assign ctl_wr = REG_WR && REG_ADDR == 8'h07;

  // Last crystal settings written; outputs must follow within two edges
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      xa_r <= 7'h00;
      xb_r <= 7'h00;
    end else if (REG_WR && REG_ADDR == 8'h04) begin
      xa_r <= {REG_WDATA[15:12], REG_WDATA[10:8]};
    end else if (REG_WR && REG_ADDR == 8'h0A) begin
      xb_r <= {REG_WDATA[15:12], REG_WDATA[11:9]};
    end
  end

  property p_mode_int;
    ctl_wr && REG_WDATA[31:29] == 3'h0 && !REG_WDATA[2] |-> ##3 PLL1_MODE == PFDC_MODE_INT;
  endproperty
  a_mode_int: assert property (p_mode_int) else $error("integer mode missing");
  property p_mode_frac;
    ctl_wr && REG_WDATA[31:29] inside {3'h1, 3'h2, 3'h3, 3'h4} && !REG_WDATA[2]
      |-> ##3 PLL1_MODE == PFDC_MODE_FRAC;
  endproperty
  a_mode_frac: assert property (p_mode_frac) else $error("fractional mode missing");
  property p_mode_rat;
    ctl_wr && REG_WDATA[31:29] != 3'h0 && REG_WDATA[2] |-> ##3 PLL1_MODE == PFDC_MODE_RAT;
  endproperty
  a_mode_rat: assert property (p_mode_rat) else $error("rational mode missing");
  property p_rst_req;
    ctl_wr && REG_WDATA[14] |-> ##[1:2] PLL1_DIV_RST;
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("divider reset missing");
  property p_rst_pulse;
    PLL1_DIV_RST |=> !PLL1_DIV_RST;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("divider reset too long");
  property p_ref_pick;
    REG_WR && REG_ADDR == 8'h02 && REG_WDATA[5:4] == 2'h3 |-> ##3 (PLL1_REF_B && OSC_B_ON);
  endproperty
  a_ref_pick: assert property (p_ref_pick) else $error("second reference not used");
  property p_cap_a;
    REG_WR && REG_ADDR == 8'h04 |-> ##2 XTAL_A_CFG == xa_r;
  endproperty
  a_cap_a: assert property (p_cap_a) else $error("crystal a settings wrong");
  property p_cap_b;
    REG_WR && REG_ADDR == 8'h0A |-> ##2 XTAL_B_CFG == xb_r;
  endproperty
  a_cap_b: assert property (p_cap_b) else $error("crystal b settings wrong");
endmodule : pfdc_checker

// File: pll_feedback_divider_ctrl_tb_top.sv
/*
  Self-checking bench for pfdc_ctrl, checker bound at the foot.
  Assumes the package, design and checker are compiled first.
*/
`timescale 1ns/100ps
module pll_feedback_divider_ctrl_tb_top
  import pfdc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [35:0] wdata = 36'h0;
  logic [35:0] rdata;
  logic [8:0] wh1, wh2;
  logic [2:0] ph1, ph2;
  pfdc_mode_type md1, md2;
  logic rb1, rb2, dr1, dr2, oa, ob;
  pfdc_xtal_cfg_type xa, xb;
  int errors = 0;
  int comparisons = 0;
  int n_dr1 = 0;
  int n_dr2 = 0;

  always #20 clk = ~clk;

  pfdc_ctrl dut (
    .REF_CLK(clk), .RSTN(rstn), .REG_WR(wr_en), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .PLL1_FB_WHOLE(wh1), .PLL1_FB_PHASE(ph1), .PLL2_FB_WHOLE(wh2),
    .PLL2_FB_PHASE(ph2), .PLL1_MODE(md1), .PLL2_MODE(md2), .PLL1_REF_B(rb1),
    .PLL2_REF_B(rb2), .PLL1_DIV_RST(dr1), .PLL2_DIV_RST(dr2), .OSC_A_ON(oa),
    .OSC_B_ON(ob), .XTAL_A_CFG(xa), .XTAL_B_CFG(xb)
  );

  // Pulse counters; a pulse may land on any edge, so count rather than poll
  always @(posedge clk) begin
    if (dr1 === 1'b1) n_dr1++;
    if (dr2 === 1'b1) n_dr2++;
  end

  function automatic logic [35:0] ctl(logic [2:0] o, logic [1:0] s, logic r, logic d);
    return {4'h0, o, 1'b0, s, 11'h0, d, 11'h0, r, 2'h0};
  endfunction : ctl

  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(logic [35:0] got, logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic near(logic [31:0] got, logic [31:0] exp, logic [31:0] tol);
    comparisons++;
    if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: sum %0d expected %0d", $time, got, exp);
    end
  endtask : near

  // Write, then idle three edges so outputs have settled on return
  task automatic wr(logic [7:0] a, logic [35:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [35:0] exp);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1;
    chk(rdata, exp);
  endtask : rd

  // Sum of divide values in eighths over n cycles
  task automatic sum(int n, output logic [31:0] s);
    s = 32'h0;
    repeat (n) begin
      @(posedge clk);
      #1;
      s = s + {20'h0, wh1, 3'h0} + {29'h0, ph1};
    end
  endtask : sum

  task automatic t_reset;
    chk(md1, PFDC_MODE_INT);
    chk(oa, 1'b1);
    chk(ob, 1'b0);
    rd(8'h07, 36'h0);
    wr(8'h05, 36'hF_FFFF_FFFF);
    rd(8'h05, 36'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_modes;
    pfdc_mode_type m;
    for (int o = 0; o < 5; o++) begin
      for (int r = 0; r < 2; r++) begin
        m = r ? PFDC_MODE_RAT : o ? PFDC_MODE_FRAC : PFDC_MODE_INT;
        if (o == 0 && r == 1) continue;
        wr(8'h07, ctl(o[2:0], 2'h3, r[0], 1'b1));
        wr(8'h09, ctl(o[2:0], 2'h3, r[0], 1'b1));
        chk(md1, m);
        chk(md2, m);
      end
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_int;
    logic [2:0] f;
    for (int s = 0; s < 4; s++) begin
      f = s == 0 ? 3'h5 : s == 1 ? 3'h6 : s == 2 ? 3'h4 : 3'h0;
      wr(8'h06, {8'h2A, f, 25'h0});
      wr(8'h07, ctl(3'h0, s[1:0], 1'b0, 1'b1));
      wr(8'h08, {8'h2A, f, 25'h0});
      wr(8'h09, ctl(3'h0, s[1:0], 1'b0, 1'b1));
      repeat (4) begin
        chk(wh1, 9'h02A);
        chk(ph1, f);
        chk(wh2, 9'h02A);
        chk(ph2, f);
        chk(md1, PFDC_MODE_INT);
        @(posedge clk);
        #1;
      end
    end
    $display("test integer done");
  endtask : t_int

  task automatic t_rst;
    int a;
    int b;
    a = n_dr1;
    b = n_dr2;
    wr(8'h07, ctl(3'h2, 2'h0, 1'b0, 1'b1));
    wr(8'h09, ctl(3'h1, 2'h1, 1'b0, 1'b1));
    chk(36'(n_dr1 - a), 36'h1);
    chk(36'(n_dr2 - b), 36'h1);
    rd(8'h07, ctl(3'h2, 2'h0, 1'b0, 1'b0));
    $display("test divider_reset done");
  endtask : t_rst

  task automatic t_frac;
    logic [2:0] od [3] = '{3'h1, 3'h2, 3'h4};
    logic [1:0] sl [3] = '{2'h3, 2'h0, 2'h1};
    logic [35:0] dv [3] = '{36'h0A_800_0000, 36'h14_400_0000, 36'hFF_FFF_FFFF};
    logic [31:0] ex [3] = '{32'h2A00, 32'h5100, 32'h40000};
    logic [31:0] s;
    for (int i = 0; i < 3; i++) begin
      wr(8'h06, dv[i]);
      wr(8'h07, ctl(od[i], sl[i], 1'b0, 1'b1));
      sum(128, s);
      near(s, ex[i], 32'h80);
    end
    $display("test fractional done");
  endtask : t_frac

  task automatic t_rat;
    logic [27:0] f;
    logic [31:0] s;
    wr(8'h10, 36'h3);
    rd(8'h10, 36'h3);
    for (int k = 0; k < 4; k++) begin
      f = (k < 3 ? 28'h1 << (25 + k) : 28'h0) | 28'h400;
      wr(8'h06, {8'h07, f});
      wr(8'h07, ctl(3'h1, k[1:0], 1'b1, 1'b1));
      chk(md1, PFDC_MODE_RAT);
      sum(192, s);
      near(s, 32'h2A00 + (((k < 3 ? 32'h600 : 32'h0) + 32'h400) >> (3 - k)),
        32'h18);
    end
    $display("test rational done");
  endtask : t_rat

  task automatic t_ref;
    wr(8'h02, 36'h30);
    chk({rb1, rb2, ob}, 3'h5);
    wr(8'h02, 36'hC0);
    chk({rb1, rb2, ob}, 3'h3);
    wr(8'h02, 36'h20);
    chk({rb1, rb2, ob}, 3'h0);
    wr(8'h0A, 36'h100);
    chk(ob, 1'b1);
    wr(8'h0A, 36'h2C00);
    chk({ob, xb}, 8'h16);
    wr(8'h04, 36'hD300);
    chk(xa, 7'h6B);
    rd(8'h04, 36'hD300);
    wr(8'h02, 36'hF0);
    wr(8'h03, 36'h800_0000);
    chk({oa, ob}, 2'h1);
    wr(8'h03, 36'hC00_0000);
    chk({oa, ob}, 2'h3);
    $display("test reference done");
  endtask : t_ref

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    t_reset();
    t_modes();
    t_int();
    t_rst();
    t_frac();
    t_rat();
    t_ref();
    stop_test();
  end

  // Tests need about 1500 cycles; this bound cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : pll_feedback_divider_ctrl_tb_top

bind pfdc_ctrl pfdc_checker u_chk (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .PLL1_MODE(PLL1_MODE), .PLL1_REF_B(PLL1_REF_B),
  .PLL1_DIV_RST(PLL1_DIV_RST), .OSC_B_ON(OSC_B_ON), .XTAL_A_CFG(XTAL_A_CFG),
  .XTAL_B_CFG(XTAL_B_CFG)
);
